//--- shared/ppt_pkg.sv
package ppt_pkg;

	localparam int CNT_W = 8;

	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_IOCTL = 8'h04;
	localparam logic [7:0] OFS_MODE  = 8'h08;
	localparam logic [7:0] OFS_PRE   = 8'h0c;
	localparam logic [7:0] OFS_TMR   = 8'h10;

	localparam int BIT_START = 0;
	localparam int BIT_CSF   = 1;
	localparam int BIT_STOP  = 2;
	localparam int BIT_EDGF  = 4;
	localparam int BIT_UNDF  = 5;

	localparam int BIT_LVL   = 0;
	localparam int BIT_PSTOP = 1;
	localparam int BIT_INVEN = 2;
	localparam int BIT_ROUTE = 3;

	localparam int MODE_LSB = 0;
	localparam int SRC_LSB  = 4;

	localparam logic [7:0] RST_CNT = 8'hff;

	localparam int OSC_DIV_DEF = 4;
	localparam int SUB_DIV_DEF = 8192;

	typedef enum logic [2:0] {
		MODE_TIMER  = 3'h0,
		MODE_PULSE  = 3'h1,
		MODE_EVENT  = 3'h2,
		MODE_WIDTH  = 3'h3,
		MODE_PERIOD = 3'h4
	} ppt_mode_e;

	typedef enum logic [2:0] {
		SRC_F1  = 3'h0,
		SRC_F8  = 3'h1,
		SRC_OSC = 3'h2,
		SRC_F2  = 3'h3,
		SRC_SUB = 3'h4
	} ppt_src_e;

	typedef enum logic [1:0] {
		ST_STOP  = 2'b01,
		ST_COUNT = 2'b10
	} ppt_run_e;

	typedef struct packed {
		logic             clr;
		logic             wr;
		logic             run;
		logic             dec;
		logic [CNT_W-1:0] wdata;
	} ppt_cnt_ctl_s;

endpackage

//--- verilog/ppt_src_div.sv
`timescale 1ns/1ns
`default_nettype none
module ppt_src_div import ppt_pkg::*; #(
	parameter int OSC_DIV = OSC_DIV_DEF,
	parameter int SUB_DIV = SUB_DIV_DEF
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire ppt_src_e   sel_i,
	output logic            tick_o
);
	typedef struct packed {
		logic        c2;
		logic [2:0]  c8;
		logic [15:0] co;
		logic [15:0] cs;
		logic        tick;
	} ppt_div_s;

	ppt_div_s s_q, s_d;
	logic     t8, to, ts;

	// Every rate but SRC_F1, which holds the enable high, is a one-cycle enable of the single system clock.
	always_comb begin
		s_d  = s_q;
		t8   = (s_q.c8 == 3'h7);
		to   = (s_q.co == 16'(OSC_DIV - 1));
		ts   = (s_q.cs == 16'(SUB_DIV - 1));
		s_d.c2 = ~s_q.c2;
		s_d.c8 = s_q.c8 + 3'h1;
		s_d.co = to ? 16'h0000 : s_q.co + 16'h0001;
		s_d.cs = ts ? 16'h0000 : s_q.cs + 16'h0001;
		case (sel_i)
			SRC_F1:  s_d.tick = 1'b1;
			SRC_F2:  s_d.tick = s_q.c2;
			SRC_F8:  s_d.tick = t8;
			SRC_OSC: s_d.tick = to;
			SRC_SUB: s_d.tick = ts;
			default: s_d.tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;
endmodule
`default_nettype wire

//--- verilog/ppt_reload_cnt.sv
`timescale 1ns/1ns
`default_nettype none
module ppt_reload_cnt import ppt_pkg::*; (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire ppt_cnt_ctl_s ctl_i,
	output logic [CNT_W-1:0]  cnt_o,
	output logic              unf_o
);
	typedef struct packed {
		logic [CNT_W-1:0] rld;
		logic [CNT_W-1:0] cnt;
		logic             pend;
		logic             unf;
	} ppt_rc_s;

	ppt_rc_s s_q, s_d;

	always_comb begin
		s_d     = s_q;
		s_d.unf = 1'b0;
		if (ctl_i.clr) begin
			s_d.rld  = RST_CNT;
			s_d.cnt  = RST_CNT;
			s_d.pend = 1'b0;
		end else begin
			if (ctl_i.wr) begin
				s_d.rld = ctl_i.wdata;
			end
			if (ctl_i.wr && !ctl_i.run) begin
				s_d.cnt  = ctl_i.wdata;
				s_d.pend = 1'b0;
			end else if (ctl_i.dec) begin
				if (s_q.pend) begin
					s_d.cnt = s_d.rld;
				end else if (s_q.cnt == '0) begin
					s_d.cnt = s_d.rld;
					s_d.unf = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 1'b1;
				end
				s_d.pend = ctl_i.wr;
			end else if (ctl_i.wr) begin
				// Held until the next decrement keeps the count coherent.
				s_d.pend = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '{rld: RST_CNT, cnt: RST_CNT, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign cnt_o = s_q.cnt;
	assign unf_o = s_q.unf;
endmodule
`default_nettype wire

//--- verilog/ppt_timer.sv
`timescale 1ns/1ns
`default_nettype none
module ppt_timer import ppt_pkg::*; #(
	parameter int OSC_DIV = OSC_DIV_DEF,
	parameter int SUB_DIV = SUB_DIV_DEF
) (
	input  wire logic        CLOCK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic             PIN_A_O,
	output logic             PIN_A_OE_O,
	output logic             PIN_B_O,
	output logic             PIN_B_OE_O,
	output logic             INV_PIN_O,
	output logic             INV_PIN_OE_O,
	output logic             TIMER_IRQ_O
);
	typedef struct packed {
		ppt_run_e    run;
		logic        start;
		logic        edgf;
		logic        undf;
		logic        level;
		logic        lvl_sel;
		logic        pstop;
		logic        inven;
		logic        route;
		ppt_mode_e   mode;
		ppt_src_e    src;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        pin_a;
		logic        pin_a_oe;
		logic        pin_b;
		logic        pin_b_oe;
		logic        inv;
		logic        inv_oe;
		logic        irq;
	} ppt_top_s;

	ppt_top_s s_q, s_d;

	ppt_cnt_ctl_s     pre_ctl;
	ppt_cnt_ctl_s     tmr_ctl;
	logic [CNT_W-1:0] pre_cnt;
	logic [CNT_W-1:0] tmr_cnt;
	logic             pre_unf;
	logic             tmr_unf;
	logic             src_tick;

	logic             acc;
	logic             wr;
	logic             wr_ctrl;
	logic             wr_io;
	logic             wr_mode;
	logic             wr_pre;
	logic             wr_tmr;
	logic             fstop;
	logic             counting;
	logic             pulse_en;

	function automatic logic hit(input logic [7:0] a,
			input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, OFS_CTRL) | hit(a, OFS_IOCTL) |
			hit(a, OFS_MODE) | hit(a, OFS_PRE) | hit(a, OFS_TMR);
	endfunction

	ppt_src_div #(
		.OSC_DIV (OSC_DIV),
		.SUB_DIV (SUB_DIV)
	) u_div (
		.clk_i  (CLOCK_I),
		.rst_i  (SYS_RST_I),
		.sel_i  (s_q.src),
		.tick_o (src_tick)
	);

	ppt_reload_cnt u_pre (
		.clk_i (CLOCK_I),
		.rst_i (SYS_RST_I),
		.ctl_i (pre_ctl),
		.cnt_o (pre_cnt),
		.unf_o (pre_unf)
	);

	ppt_reload_cnt u_tmr (
		.clk_i (CLOCK_I),
		.rst_i (SYS_RST_I),
		.ctl_i (tmr_ctl),
		.cnt_o (tmr_cnt),
		.unf_o (tmr_unf)
	);

	// A write lands on the edge that samples pready high.
	always_comb begin
		acc      = PSEL_I & PENABLE_I & s_q.pready;
		wr       = acc & PWRITE_I & mapped(PADDR_I);
		wr_ctrl  = wr & hit(PADDR_I, OFS_CTRL);
		wr_io    = wr & hit(PADDR_I, OFS_IOCTL);
		wr_mode  = wr & hit(PADDR_I, OFS_MODE);
		wr_pre   = wr & hit(PADDR_I, OFS_PRE);
		wr_tmr   = wr & hit(PADDR_I, OFS_TMR);
		fstop    = wr_ctrl & PWDATA_I[BIT_STOP];
		counting = (s_q.run == ST_COUNT);
		pulse_en = (s_q.mode == MODE_PULSE);
	end

	always_comb begin
		pre_ctl       = '0;
		pre_ctl.clr   = fstop;
		pre_ctl.wr    = wr_pre;
		pre_ctl.run   = counting;
		pre_ctl.dec   = counting & src_tick;
		pre_ctl.wdata = PWDATA_I[CNT_W-1:0];
		tmr_ctl       = '0;
		tmr_ctl.clr   = fstop;
		tmr_ctl.wr    = wr_tmr;
		tmr_ctl.run   = counting;
		tmr_ctl.dec   = pre_unf;
		tmr_ctl.wdata = PWDATA_I[CNT_W-1:0];
	end

	always_comb begin
		s_d         = s_q;
		s_d.irq     = tmr_unf;
		s_d.pready  = PSEL_I & PENABLE_I & ~s_q.pready;
		s_d.pslverr = PSEL_I & PENABLE_I & ~s_q.pready &
			~mapped(PADDR_I);
		if (PSEL_I & PENABLE_I & ~s_q.pready) begin
			s_d.prdata = '0;
			case (PADDR_I)
				OFS_CTRL: begin
					s_d.prdata[BIT_START] = s_q.start;
					s_d.prdata[BIT_CSF]   = counting;
					s_d.prdata[BIT_EDGF]  = s_q.edgf;
					s_d.prdata[BIT_UNDF]  = s_q.undf;
				end
				OFS_IOCTL: begin
					s_d.prdata[BIT_LVL]   = s_q.lvl_sel;
					s_d.prdata[BIT_PSTOP] = s_q.pstop;
					s_d.prdata[BIT_INVEN] = s_q.inven;
					s_d.prdata[BIT_ROUTE] = s_q.route;
				end
				OFS_MODE: begin
					s_d.prdata[MODE_LSB +: 3] = s_q.mode;
					s_d.prdata[SRC_LSB +: 3]  = s_q.src;
				end
				OFS_PRE: begin
					s_d.prdata[CNT_W-1:0] = pre_cnt;
				end
				OFS_TMR: begin
					s_d.prdata[CNT_W-1:0] = tmr_cnt;
				end
				default: begin
					s_d.prdata = '0;
				end
			endcase
		end

		if (wr_ctrl) begin
			s_d.start = PWDATA_I[BIT_START];
			// Zero clears; a one written leaves the flag alone.
			if (!PWDATA_I[BIT_EDGF]) begin
				s_d.edgf = 1'b0;
			end
			if (!PWDATA_I[BIT_UNDF]) begin
				s_d.undf = 1'b0;
			end
		end
		// Only hardware sets undf, and the set beats a clear.
		if (tmr_unf) begin
			s_d.undf = 1'b1;
		end

		if (wr_io) begin
			s_d.lvl_sel = PWDATA_I[BIT_LVL];
			s_d.pstop   = PWDATA_I[BIT_PSTOP];
			s_d.inven   = PWDATA_I[BIT_INVEN];
			s_d.route   = PWDATA_I[BIT_ROUTE];
		end

		if (wr_mode) begin
			// Unlisted codes fall back to plain timing.
			case (PWDATA_I[MODE_LSB +: 3])
				MODE_PULSE:  s_d.mode = MODE_PULSE;
				MODE_EVENT:  s_d.mode = MODE_EVENT;
				MODE_WIDTH:  s_d.mode = MODE_WIDTH;
				MODE_PERIOD: s_d.mode = MODE_PERIOD;
				default:     s_d.mode = MODE_TIMER;
			endcase
			case (PWDATA_I[SRC_LSB +: 3])
				SRC_F8:  s_d.src = SRC_F8;
				SRC_OSC: s_d.src = SRC_OSC;
				SRC_F2:  s_d.src = SRC_F2;
				SRC_SUB: s_d.src = SRC_SUB;
				default: s_d.src = SRC_F1;
			endcase
			s_d.level = ~s_q.lvl_sel;
		end else if (tmr_unf) begin
			s_d.level = ~s_q.level;
		end

		// Run state follows start only on a source edge, except that a stop write stops it at once.
		case (s_q.run)
			ST_STOP: begin
				if (s_q.start && src_tick) begin
					s_d.run = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (!s_q.start && src_tick) begin
					s_d.run = ST_STOP;
				end
			end
			default: begin
				s_d.run = ST_STOP;
			end
		endcase

		if (fstop) begin
			s_d.start = 1'b0;
			s_d.run   = ST_STOP;
		end

		s_d.pin_a    = s_q.level;
		s_d.pin_b    = s_q.level;
		s_d.pin_a_oe = pulse_en & ~s_q.pstop & ~s_q.route;
		s_d.pin_b_oe = pulse_en & ~s_q.pstop & s_q.route;
		s_d.inv      = ~s_q.level;
		s_d.inv_oe   = pulse_en & s_q.inven;
	end

	// Everything starts stopped; only software sets start.
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			s_q       <= '0;
			s_q.run   <= ST_STOP;
			s_q.mode  <= MODE_TIMER;
			s_q.src   <= SRC_F1;
			s_q.level <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign PRDATA_O     = s_q.prdata;
	assign PREADY_O     = s_q.pready;
	assign PSLVERR_O    = s_q.pslverr;
	assign PIN_A_O      = s_q.pin_a;
	assign PIN_A_OE_O   = s_q.pin_a_oe;
	assign PIN_B_O      = s_q.pin_b;
	assign PIN_B_OE_O   = s_q.pin_b_oe;
	assign INV_PIN_O    = s_q.inv;
	assign INV_PIN_OE_O = s_q.inv_oe;
	assign TIMER_IRQ_O  = s_q.irq;
endmodule
`default_nettype wire

//--- dv/ppt_timer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ppt_timer_sva (
	input  wire logic        CLOCK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic [31:0] PRDATA_O,
	input  wire logic        PREADY_O,
	input  wire logic        PSLVERR_O,
	input  wire logic        PIN_A_O,
	input  wire logic        PIN_A_OE_O,
	input  wire logic        PIN_B_OE_O,
	input  wire logic        INV_PIN_O,
	input  wire logic        INV_PIN_OE_O,
	input  wire logic        TIMER_IRQ_O
);
	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (SYS_RST_I);
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_access;
		PSEL_I && PENABLE_I && !PREADY_O ##1 PREADY_O;
	endsequence
	// The pin is registered from the level, so it moves one cycle after
	// the interrupt pulse.
	property p_toggle;
		TIMER_IRQ_O && PIN_A_OE_O |=> PIN_A_O != $past(PIN_A_O);
	endproperty
	property p_quiet;
		$fell(SYS_RST_I) |-> !TIMER_IRQ_O [*8];
	endproperty
	AST_READY_WAIT: assert property (s_setup |=> s_access)
		else $error("apb answer not in second access cycle");
	AST_READY_ONE: assert property (PREADY_O |=> !PREADY_O)
		else $error("apb ready longer than one cycle");
	AST_ERR_WITH_READY: assert property (PSLVERR_O |-> PREADY_O)
		else $error("slave error without ready");
	AST_ERR_READS_ZERO: assert property (PSLVERR_O |-> PRDATA_O == 32'h0)
		else $error("refused access returned data");
	AST_INV_PIN: assert property (INV_PIN_OE_O |-> INV_PIN_O != PIN_A_O)
		else $error("inverted pin equals pulse level");
	AST_TOGGLE_ON_IRQ: assert property (p_toggle)
		else $error("underflow without pin toggle");
	AST_ONE_ROUTE: assert property (!(PIN_A_OE_O && PIN_B_OE_O))
		else $error("both routed pins driven");
	AST_QUIET_AFTER_RESET: assert property (p_quiet)
		else $error("timer counts after reset");
endmodule
bind ppt_timer ppt_timer_sva i_ppt_timer_sva (
	.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .PIN_A_O(PIN_A_O), .PIN_A_OE_O(PIN_A_OE_O),
	.PIN_B_OE_O(PIN_B_OE_O), .INV_PIN_O(INV_PIN_O),
	.INV_PIN_OE_O(INV_PIN_OE_O), .TIMER_IRQ_O(TIMER_IRQ_O));
`default_nettype wire

//--- dv/ppt_pulse_rx.sv
`timescale 1ns/1ns
`default_nettype none
module ppt_pulse_rx (
	input  wire logic clk_i,
	input  wire logic pin_i,
	output int        edges_o,
	output int        half_o
);
	logic prev_q  = 1'b1;
	int   cnt_q   = 0;
	int   edges_q = 0;
	int   half_q  = 0;
	// The first span after the line turns active is not a full half period.
	always @(posedge clk_i) begin
		prev_q <= pin_i;
		if (pin_i !== prev_q) begin
			edges_q <= edges_q + 1;
			half_q <= cnt_q;
			cnt_q <= 1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign edges_o = edges_q;
	assign half_o  = half_q;
endmodule
`default_nettype wire

//--- dv/ppt_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ppt_timer_tb import ppt_pkg::*;;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        prdy, perr, pa, pa_oe, pb, pb_oe, inv, inv_oe, irq;
	// The line has a pull-up, so it reads high whenever the timer lets go.
	wire logic   line_a = pa_oe ? pa : 1'b1;
	int          fail_count = 0, num_checks = 0, edges, half;

	always #2 clk = ~clk;

	ppt_timer #(.OSC_DIV(4), .SUB_DIV(16)) i_ppt_timer (.CLOCK_I(clk),
		.SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(prdy), .PSLVERR_O(perr), .PIN_A_O(pa), .PIN_A_OE_O(pa_oe),
		.PIN_B_O(pb), .PIN_B_OE_O(pb_oe), .INV_PIN_O(inv),
		.INV_PIN_OE_O(inv_oe), .TIMER_IRQ_O(irq));
	ppt_pulse_rx i_ppt_pulse_rx (.clk_i(clk), .pin_i(line_a),
		.edges_o(edges), .half_o(half));

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [31:0] r, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1);
		chk("pready wait", 32'd2, n);
		r = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        er;
		apb(1'b1, a, d, r, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m,
			input logic [7:0] e, input string nm);
		logic [31:0] r;
		logic        er;
		apb(1'b0, a, 8'h00, r, er);
		chk(nm, {24'h0, e}, r & {24'hffffff, m});
	endtask

	task automatic t_reset;
		logic [31:0] r;
		logic        er;
		rd(OFS_PRE, 8'hff, 8'hff, "prescaler");
		rd(OFS_TMR, 8'hff, 8'hff, "timer");
		rd(OFS_CTRL, 8'hff, 8'h00, "control");
		apb(1'b0, 8'h20, 8'h00, r, er);
		chk("unmapped error", 32'h1, {31'h0, er});
		$display("test reset done");
	endtask
	task automatic t_pulse;
		logic [31:0] r0, r1;
		logic        er;
		int          e0, nirq;
		nirq = 0;
		wr(OFS_PRE, 8'h01);
		wr(OFS_TMR, 8'h02);
		rd(OFS_TMR, 8'hff, 8'h02, "timer load");
		wr(OFS_IOCTL, 8'h04);
		wr(OFS_MODE, 8'h01);
		repeat (2) @(posedge clk);
		chk("start level", 32'h1, {31'h0, pa});
		e0 = edges;
		wr(OFS_CTRL, 8'h01);
		rd(OFS_CTRL, 8'h02, 8'h02, "count status");
		// Each pin edge trails its interrupt pulse, so three edges span three.
		while (edges < e0 + 3) begin
			@(posedge clk);
			if (irq === 1'b1)
				nirq++;
		end
		chk("half period", 32'd6, half);
		chk("irq pulses", 32'd3, nirq);
		wr(OFS_CTRL, 8'h20);
		apb(1'b0, OFS_TMR, 8'h00, r0, er);
		// A running timer would have moved on by the 26-cycle gap.
		repeat (22) @(posedge clk);
		apb(1'b0, OFS_TMR, 8'h00, r1, er);
		chk("stopped counter", r0, r1);
		wr(OFS_CTRL, 8'h20);
		rd(OFS_CTRL, 8'h20, 8'h20, "flag kept");
		wr(OFS_CTRL, 8'h00);
		rd(OFS_CTRL, 8'h20, 8'h00, "flag cleared");
		wr(OFS_IOCTL, 8'h05);
		wr(OFS_MODE, 8'h01);
		repeat (2) @(posedge clk);
		chk("start level low", 32'h0, {31'h0, pa});
		chk("inverted pin", 32'h1, {31'h0, inv});
		chk("inverted enable", 32'h1, {31'h0, inv_oe});
		$display("test pulse done");
	endtask
	task automatic t_force;
		wr(OFS_PRE, 8'h05);
		wr(OFS_CTRL, 8'h01);
		repeat (10) @(posedge clk);
		wr(OFS_CTRL, 8'h04);
		rd(OFS_CTRL, 8'h07, 8'h00, "forced control");
		rd(OFS_PRE, 8'hff, 8'hff, "forced prescaler");
		rd(OFS_TMR, 8'hff, 8'hff, "forced timer");
		$display("test force done");
	endtask
	task automatic t_route;
		for (int m = 0; m < 5; m++) begin
			wr(OFS_MODE, 8'(m * 17));
			rd(OFS_MODE, 8'h77, 8'(m * 17), "mode and source");
		end
		wr(OFS_MODE, 8'h01);
		wr(OFS_IOCTL, 8'h0a);
		repeat (2) @(posedge clk);
		chk("pulse stop", 32'h0, {31'h0, pb_oe});
		wr(OFS_IOCTL, 8'h08);
		wr(OFS_MODE, 8'h01);
		repeat (2) @(posedge clk);
		chk("route b", 32'h1, {31'h0, pb_oe});
		chk("route a off", 32'h0, {31'h0, pa_oe});
		chk("pin b level", 32'h1, {31'h0, pb});
		$display("test route done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_pulse();
		t_force();
		t_route();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
